/* hdl/dls_status_snapshot.sv */
// APB register bank presenting captured demodulator loop values.
// assumes live loop values and qamMode are synchronous to sys_clk;
// the master follows APB setup/access order; this slave never waits.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module dls_status_snapshot #(
  parameter int ACC_W = dls_pkg::ACC_W,
  parameter int ADDR_W = dls_pkg::APB_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dls_pkg::APB_DATA_W-1:0] pwdata,
  output logic [dls_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ACC_W-1:0] pilotTrackAcc,
  input wire logic [ACC_W-1:0] carrierAvgErr,
  input wire logic [ACC_W-1:0] qamCarrierAcc,
  input wire logic qamMode
);

  localparam int DW = dls_pkg::APB_DATA_W;
  localparam int BW = dls_pkg::BYTE_W;
  localparam int NW = dls_pkg::NIBBLE_W;
  localparam int IW = dls_pkg::IDX_W;
  localparam int LW = dls_pkg::BYTE_LSB_W;

  // true when the byte address is word aligned and inside the window
  function automatic logic addrInRange(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] upper;
    upper = addr >> (IW + LW);
    addrInRange = (addr[LW-1:0] == '0) && (upper == '0);
  endfunction

  // word index taken from a byte address
  function automatic logic [IW-1:0] wordIndex(input logic [ADDR_W-1:0] addr);
    wordIndex = addr[IW+LW-1:LW];
  endfunction

  // low byte of a value
  function automatic logic [BW-1:0] lowByte(input logic [ACC_W-1:0] v);
    lowByte = v[dls_pkg::LOW_LSB +: BW];
  endfunction

  // middle byte of a value
  function automatic logic [BW-1:0] midByte(input logic [ACC_W-1:0] v);
    midByte = v[dls_pkg::MID_LSB +: BW];
  endfunction

  // top nibble in bits 3:0, reserved bits 7:4 forced to zero
  function automatic logic [BW-1:0] topNibble(input logic [ACC_W-1:0] v);
    topNibble = {{(BW - NW){1'b0}}, v[dls_pkg::TOP_LSB +: NW]};
  endfunction

  // bus phase decode
  logic setupPhase;
  logic accessWrite;
  logic addrOk;
  logic [IW-1:0] idx;

  // capture and status
  logic captureReq;
  logic valid_d;
  logic valid_q;
  logic qamAtCap_d;
  logic qamAtCap_q;

  // read path
  logic [DW-1:0] rdWord;
  logic rdErr;
  logic wrErr;
  logic [DW-1:0] prdata_d;
  logic [DW-1:0] prdata_q;
  logic pslverr_d;
  logic pslverr_q;

  // live and captured values, indexed by slot
  logic [ACC_W-1:0] liveVal [dls_pkg::NUM_VALUES];
  logic [ACC_W-1:0] snapVal [dls_pkg::NUM_VALUES];

  // zero wait states; read data is prepared during the setup cycle
  assign pready = 1'b1;

  // phase and address decode shared by read and write paths
  assign setupPhase = psel & ~penable;
  assign accessWrite = psel & penable & pwrite & pready;
  assign addrOk = addrInRange(paddr);
  assign idx = wordIndex(paddr);

  // a write of 1 to the capture bit refreshes every snapshot at once
  assign captureReq = accessWrite & addrOk & (idx == dls_pkg::IDX_CAPTURE)
                    & pwdata[dls_pkg::CAPTURE_BIT];

  // map the live inputs onto slots so one loop can capture them
  assign liveVal[dls_pkg::VAL_PILOT] = pilotTrackAcc;
  assign liveVal[dls_pkg::VAL_AVGERR] = carrierAvgErr;
  assign liveVal[dls_pkg::VAL_QAMACC] = qamCarrierAcc;

  // one snapshot register per value, all fed by the same strobe
  for (genvar g = 0; g < dls_pkg::NUM_VALUES; g++) begin : g_snap
    dls_snap_reg #(
      .WIDTH(ACC_W)
    ) u_snap (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .capture(captureReq),
      .liveVal(liveVal[g]),
      .snapVal(snapVal[g])
    );
  end

  // status flags: snapshot taken since reset, and the mode at capture time
  always_comb begin
    valid_d = valid_q | captureReq;
    qamAtCap_d = qamAtCap_q;
    if (captureReq) begin
      qamAtCap_d = qamMode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      valid_q <= 1'b0;
      qamAtCap_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      qamAtCap_q <= qamAtCap_d;
    end
  end

  // read decode; narrower registers sit in the low bits, rest reads zero
  always_comb begin
    rdWord = '0;
    rdErr = 1'b0;
    if (!addrOk) begin
      rdErr = 1'b1;
    end else begin
      case (idx)
        dls_pkg::IDX_CAPTURE: begin
          rdWord = '0; // trigger only, nothing stored
        end
        dls_pkg::IDX_SNAP_STATUS: begin
          rdWord[dls_pkg::STAT_VALID_BIT] = valid_q;
          rdWord[dls_pkg::STAT_QAM_BIT] = qamAtCap_q;
        end
        dls_pkg::IDX_PILOT_TRACK_ACC_LOW: begin
          rdWord[BW-1:0] = lowByte(snapVal[dls_pkg::VAL_PILOT]);
        end
        dls_pkg::IDX_PILOT_TRACK_ACC_MID: begin
          rdWord[BW-1:0] = midByte(snapVal[dls_pkg::VAL_PILOT]);
        end
        dls_pkg::IDX_PILOT_TRACK_ACC_TOP: begin
          rdWord[BW-1:0] = topNibble(snapVal[dls_pkg::VAL_PILOT]);
        end
        dls_pkg::IDX_CARRIER_AVG_ERR_LOW: begin
          rdWord[BW-1:0] = lowByte(snapVal[dls_pkg::VAL_AVGERR]);
        end
        dls_pkg::IDX_CARRIER_AVG_ERR_MID: begin
          rdWord[BW-1:0] = midByte(snapVal[dls_pkg::VAL_AVGERR]);
        end
        dls_pkg::IDX_CARRIER_AVG_ERR_TOP: begin
          rdWord[BW-1:0] = topNibble(snapVal[dls_pkg::VAL_AVGERR]);
        end
        dls_pkg::IDX_QAM_CARRIER_ACC_LOW: begin
          rdWord[BW-1:0] = lowByte(snapVal[dls_pkg::VAL_QAMACC]);
        end
        dls_pkg::IDX_QAM_CARRIER_ACC_MID: begin
          rdWord[BW-1:0] = midByte(snapVal[dls_pkg::VAL_QAMACC]);
        end
        dls_pkg::IDX_QAM_CARRIER_ACC_TOP: begin
          rdWord[BW-1:0] = topNibble(snapVal[dls_pkg::VAL_QAMACC]);
        end
        default: begin
          rdErr = 1'b1; // unmapped word
        end
      endcase
    end
  end

  // only the capture register accepts writes; the rest are read-only
  always_comb begin
    wrErr = 1'b1;
    if (addrOk && (idx == dls_pkg::IDX_CAPTURE)) begin
      wrErr = 1'b0;
    end
  end

  // answer latched in the setup cycle, so prdata and pslverr are
  // flop outputs and still stand at the access edge with pready high
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setupPhase) begin
      if (pwrite) begin
        prdata_d = '0;
        pslverr_d = wrErr;
      end else begin
        prdata_d = rdWord;
        pslverr_d = rdErr;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_q <= dls_pkg::RDATA_RESET;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // hazard: a capture write in the access cycle takes effect at that
  // edge, so a read set up one cycle later already sees the new sample
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

endmodule

/* hdl/dls_pkg.sv */
// constants shared by the loop status snapshot block and its bench.
// assumes a 32-bit APB with word-aligned registers; each printed
// offset is a word index and the byte address is four times it.
package dls_pkg;

  // bus shape
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int BYTE_LSB_W = 2;

  // value shape
  localparam int ACC_W = 20;
  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int NUM_VALUES = 3;

  // slots of the three sampled values
  localparam int VAL_PILOT = 0;
  localparam int VAL_AVGERR = 1;
  localparam int VAL_QAMACC = 2;

  // bit positions inside each value
  localparam int LOW_LSB = 0;
  localparam int MID_LSB = 8;
  localparam int TOP_LSB = 16;

  // register word indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_CAPTURE = 6'h25;
  localparam logic [IDX_W-1:0] IDX_SNAP_STATUS = 6'h26;
  localparam logic [IDX_W-1:0] IDX_PILOT_TRACK_ACC_LOW = 6'h34;
  localparam logic [IDX_W-1:0] IDX_PILOT_TRACK_ACC_MID = 6'h35;
  localparam logic [IDX_W-1:0] IDX_PILOT_TRACK_ACC_TOP = 6'h36;
  localparam logic [IDX_W-1:0] IDX_CARRIER_AVG_ERR_LOW = 6'h39;
  localparam logic [IDX_W-1:0] IDX_CARRIER_AVG_ERR_MID = 6'h3A;
  localparam logic [IDX_W-1:0] IDX_CARRIER_AVG_ERR_TOP = 6'h3B;
  localparam logic [IDX_W-1:0] IDX_QAM_CARRIER_ACC_LOW = 6'h3C;
  localparam logic [IDX_W-1:0] IDX_QAM_CARRIER_ACC_MID = 6'h3D;
  localparam logic [IDX_W-1:0] IDX_QAM_CARRIER_ACC_TOP = 6'h3E;

  // field positions
  localparam int CAPTURE_BIT = 0;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_QAM_BIT = 1;

  // reset values
  localparam logic [ACC_W-1:0] SNAP_RESET = 20'h00000;
  localparam logic [APB_DATA_W-1:0] RDATA_RESET = 32'h00000000;

endpackage

/* hdl/dls_snap_reg.sv */
// one capture register holding a multi-bit sample of a live value.
// assumes the capture strobe is a single-cycle pulse in sys_clk.
`timescale 1ns/1ps
module dls_snap_reg #(
  parameter int WIDTH = dls_pkg::ACC_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic capture,
  input wire logic [WIDTH-1:0] liveVal,
  output logic [WIDTH-1:0] snapVal
);

  logic [WIDTH-1:0] snap_d;
  logic [WIDTH-1:0] snap_q;

  // all bits load on the same edge so bytes never mix two samples
  always_comb begin
    snap_d = snap_q;
    if (capture) begin
      snap_d = liveVal;
    end
  end

  // plain storage, cleared by the synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      snap_q <= WIDTH'(dls_pkg::SNAP_RESET);
    end else begin
      snap_q <= snap_d;
    end
  end

  assign snapVal = snap_q;

endmodule

/* verif/dls_status_snapshot_chk.sv */
// assertions on the loop status snapshot register bank.
// assumes a bind to the top module; sees its ports only.
`timescale 1ns/1ps
module dls_status_snapshot_chk #(
  parameter int ACC_W = 20,
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ACC_W-1:0] pilotTrackAcc,
  input wire logic [ACC_W-1:0] carrierAvgErr,
  input wire logic [ACC_W-1:0] qamCarrierAcc,
  input wire logic qamMode
);
  logic [65:0] snap_q, snap_d;
  logic rd, wr, capWr;
  // setup phases and the capture access
  assign rd = psel && !penable && !pwrite;
  assign wr = psel && !penable && pwrite;
  assign capWr = psel && penable && pwrite && paddr == 8'h94 && pwdata[0];
  // shadow of all snapshots plus the status pair (mode, captured) on top
  always_comb begin
    snap_d = snap_q;
    if (capWr) begin
      snap_d = {qamMode, 1'b1, 4'h0, qamCarrierAcc, carrierAvgErr, pilotTrackAcc};
    end
  end
  always_ff @(posedge sys_clk) begin
    snap_q <= resetn ? snap_d : 66'h0;
  end
  // byte a read should return; top slices are masked to a nibble
  function automatic logic [31:0] expv(input logic [7:0] a, input logic [63:0] s);
    logic [3:0] i;
    i = 4'((a - 8'hD0) >> 2);
    // two unmapped words sit below the average error group; the qam group follows it directly
    if (a >= 8'hE4) i = i - 4'h2;
    expv = {24'h0, s[i/3*20 + i%3*8 +: 8] & ((i%3 == 2) ? 8'h0F : 8'hFF)};
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_pilot_top: assert property (rd && paddr == 8'hD8
    |=> prdata == expv(paddr, snap_q[63:0])) else $error("pilot top nibble wrong");
  chk_err_bytes: assert property (rd && paddr inside {8'hE4, 8'hE8, 8'hEC}
    |=> prdata == expv(paddr, snap_q[63:0])) else $error("average error byte wrong");
  chk_qam_bytes: assert property (rd && paddr inside {8'hF0, 8'hF4, 8'hF8}
    |=> prdata == expv(paddr, snap_q[63:0])) else $error("qam accumulator byte wrong");
  chk_pilot_low: assert property (rd && paddr inside {8'hD0, 8'hD4}
    |=> prdata == expv(paddr, snap_q[63:0])) else $error("pilot low bytes wrong");
  chk_top_zero: assert property (rd && paddr inside {8'hD8, 8'hEC, 8'hF8}
    |=> prdata[31:4] == 28'h0) else $error("reserved top bits not zero");
  chk_capture_ok: assert property (wr && paddr == 8'h94
    |=> pready && !pslverr) else $error("capture write refused");
  chk_capture_flag: assert property (rd && paddr == 8'h98
    |=> prdata == {30'h0, snap_q[65:64]}) else $error("capture not recorded");
  chk_ro_refused: assert property (wr && paddr inside {[8'hD0:8'hF8]}
    |=> pslverr && prdata == 32'h0) else $error("status write accepted");
endmodule

/* verif/testbench.sv */
// self-checking bench for the loop status snapshot register bank.
// assumes the design answers APB in one access cycle; one clock.
`timescale 1ns/1ps
module testbench;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, qamMode, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [19:0] pilotTrackAcc, carrierAvgErr, qamCarrierAcc;
  logic [7:0] regs [9] = '{8'hD0, 8'hD4, 8'hD8, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4, 8'hF8};
  int mismatches, cmpCount;
  dls_status_snapshot dut (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pilotTrackAcc(pilotTrackAcc), .carrierAvgErr(carrierAvgErr),
    .qamCarrierAcc(qamCarrierAcc), .qamMode(qamMode));
  // free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // one APB transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmpCount++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // capture, disturb live inputs, read every byte and the status back
  task automatic s_capture(input logic [59:0] v, input logic m);
    {qamCarrierAcc, carrierAvgErr, pilotTrackAcc} <= v;
    qamMode <= m;
    apb(1'b1, 8'h94, 32'h1);
    check({31'h0, e}, 32'h0);
    {qamCarrierAcc, carrierAvgErr, pilotTrackAcc} <= ~v;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, regs[i], 32'h0);
      check(rdat, {24'h0, v[i/3*20 + i%3*8 +: 8] & ((i%3 == 2) ? 8'h0F : 8'hFF)});
    end
    apb(1'b0, 8'h98, 32'h0);
    check(rdat, {30'h0, m, 1'b1});
  endtask
  // refused and ineffective accesses leave the snapshot alone
  task automatic s_refuse();
    apb(1'b1, 8'h94, 32'h0);
    check({31'h0, e}, 32'h0);
    apb(1'b1, 8'hD8, 32'hF);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 8'hD8, 32'h0);
    check(rdat, 32'h00000005);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, e}, 32'h1);
    check(rdat, 32'h0);
    apb(1'b0, 8'hD9, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, 8'h98, 32'h3);
    check({31'h0, e}, 32'h1);
  endtask
  task automatic wrapUp();
    $display("comparisons %0d, mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog; the whole run needs well under 5 us
  initial begin
    #20us;
    mismatches++;
    wrapUp();
  end
  // main sequence, with a second reset in mid-run
  initial begin
    {resetn, psel, penable, pwrite, qamMode, paddr, pwdata} = '0;
    {pilotTrackAcc, carrierAvgErr, qamCarrierAcc} = '0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    s_capture({20'hFEDCB, 20'h12345, 20'hA5A5A}, 1'b1);
    s_capture({20'h0123A, 20'hEDCBA, 20'h5A5A5}, 1'b0);
    s_refuse();
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, 8'hF8, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 8'h98, 32'h0);
    check(rdat, 32'h0);
    wrapUp();
  end
endmodule
bind dls_status_snapshot dls_status_snapshot_chk #(.ACC_W(ACC_W), .ADDR_W(ADDR_W)) chk (
  .sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pilotTrackAcc(pilotTrackAcc), .carrierAvgErr(carrierAvgErr),
  .qamCarrierAcc(qamCarrierAcc), .qamMode(qamMode));
